// *** logic/pss_regs.svh ***
// Timing and field constants for the power state sequencer
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// Beacon interval, in cycles of the low power tick, or in reference clock cycles while that clock is absent
`define PSS_BEACON_TICKS_DEF   16'h0064
// Beacon receive window, in reference clock cycles
`define PSS_BEACON_RX_DEF      16'h0100
// Low power clock presence: cycles without an edge before it is lost
`define PSS_LPCLK_TIMEOUT_DEF  16'h0800
// Start-up sequence length in reference clock cycles
`define PSS_STARTUP_DEF        16'h0040
`define PSS_CNT_W              16
`define PSS_CNT_ONE            16'h0001
`define PSS_CNT_ZERO           16'h0000
`endif

// *** logic/pss_pkg.sv ***
// Types shared by the power state sequencer files
`default_nettype none
package pss_pkg;
  typedef enum logic [6:0] {
    ST_RESET   = 7'h01,
    ST_STARTUP = 7'h02,
    ST_LISTEN  = 7'h04,
    ST_SLEEP   = 7'h08,
    ST_SLP_XO  = 7'h10,
    ST_SNOOZE  = 7'h20,
    ST_SHUTDN  = 7'h40
  } pwr_state_t;
endpackage
`default_nettype wire

// *** logic/lp_clock_sense.sv ***
// Synchroniser and presence detector for the low power clock pin
`timescale 1ns/1ns
`default_nettype none
`include "pss_regs.svh"
module lp_clock_sense #(
  parameter logic [15:0] TIMEOUT = `PSS_LPCLK_TIMEOUT_DEF
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Pin and results
  input  wire logic low_power_clock_in,
  output logic      lp_tick,
  output logic      lp_present
);
  typedef struct packed {
    logic [2:0]  sync;
    logic [15:0] idle;
    logic        tick;
    logic        lvl;
    logic        present;
  } sense_t;
  sense_t s_q, s_d;

  // Three stage sync; the level moves once stages two and three agree,
  // so a sample caught mid-transition is never taken as an edge
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], low_power_clock_in};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.lvl = s_q.sync[2];
    end
    s_d.tick = s_d.lvl & ~s_q.lvl;
    if (s_d.tick) begin
      s_d.idle    = `PSS_CNT_ZERO;
      s_d.present = 1'h1;
    end else if (s_q.idle == TIMEOUT) begin
      s_d.present = 1'h0; // No edge for too long: clock absent
    end else begin
      s_d.idle = s_q.idle + `PSS_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lp_tick    = s_q.tick;
  assign lp_present = s_q.present;
endmodule
`default_nettype wire

// *** logic/power_state_sequencer.sv ***
// Power state sequencer: listen, sleep variants, shutdown and reset
// Notes on behaviour
// - Power save off, no traffic: remain in listen.
// - Power save on: enter low power, wake periodically for beacons.
// - Low power clock present: use sleep, crystal and host interface off.
// - No low power clock or crystal required: sleep with crystal on.
// - No low power clock: snooze allowed, crystal always on.
// - Unassociated: low power only if idle and wake request low.
// - Shutdown left while the reset pin is low; full start-up sequence follows its rise.
`timescale 1ns/1ns
`default_nettype none
`include "pss_regs.svh"
module power_state_sequencer #(
  parameter logic [15:0] BEACON_TICKS = `PSS_BEACON_TICKS_DEF,
  parameter logic [15:0] BEACON_RX    = `PSS_BEACON_RX_DEF,
  parameter logic [15:0] STARTUP      = `PSS_STARTUP_DEF,
  parameter logic [15:0] LP_TIMEOUT   = `PSS_LPCLK_TIMEOUT_DEF
) (
  // Clock and reset (reset is the external reset pin, synchronous)
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Pins from the host and low power clock
  input  wire logic wake_request_pin,
  input  wire logic low_power_clock_in,
  // Firmware controls
  input  wire logic power_save_en,
  input  wire logic keep_crystal_on,
  input  wire logic prefer_snooze,
  input  wire logic associated,
  input  wire logic traffic_busy,
  input  wire logic tasks_pending,
  input  wire logic shutdown_req,
  // Power controls and status
  output logic      crystal_oscillator_en,
  output logic      host_if_en,
  output logic      core_power_en,
  output logic      beacon_rx,
  output logic      startup_busy,
  output logic[6:0] power_state
);
  typedef struct packed {
    pss_pkg::pwr_state_t st;
    logic [2:0]          wake_sync;
    logic                wake_lvl;
    logic [15:0]         cnt;
    logic                rx;
    logic                xo;
    logic                hif;
    logic                core;
    logic                boot;
  } seq_t;
  seq_t q, d;

  logic        lp_tick;
  logic        lp_present;
  logic        wake_hi;
  logic        rest_quiet;
  logic        rest_unassoc_ok;
  logic        may_rest;
  logic        rest_count;
  logic        beacon_due;
  logic        window_open;
  logic        startup_done;
  logic [15:0] cnt_inc;

  lp_clock_sense #(.TIMEOUT(LP_TIMEOUT)) u_sense (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .low_power_clock_in (low_power_clock_in),
    .lp_tick            (lp_tick),
    .lp_present         (lp_present)
  );

  // Filtered wake level, updated in the next-state process
  assign wake_hi = q.wake_lvl;

  // Nothing in flight and the host is not asking for the interface
  assign rest_quiet = power_save_en & ~traffic_busy & ~wake_hi;

  // Unassociated rest also needs an empty task list
  assign rest_unassoc_ok = associated | ~tasks_pending;
  assign may_rest        = rest_quiet & rest_unassoc_ok;

  // Rest timing runs on the low power tick when the slow clock is there;
  // without it the reference clock counts, which costs power but still
  // brings the device back for every beacon
  assign rest_count = lp_tick | ~lp_present;
  assign beacon_due = (q.cnt == BEACON_TICKS);

  // Beacon receive window and start-up length, both in reference cycles
  assign window_open  = q.rx && (q.cnt != BEACON_RX);
  assign startup_done = (q.cnt == STARTUP);

  // Shared counter step; every count is cleared long before it wraps
  assign cnt_inc = q.cnt + `PSS_CNT_ONE;

  // Pick the low power variant for the current clock situation
  function automatic pss_pkg::pwr_state_t pick_rest(input logic lp_ok,
                                                    input logic keep_xo,
                                                    input logic snz);
    if (lp_ok && !keep_xo) begin
      pick_rest = pss_pkg::ST_SLEEP;
    end else if (!lp_ok && snz) begin
      pick_rest = pss_pkg::ST_SNOOZE;
    end else begin
      pick_rest = pss_pkg::ST_SLP_XO;
    end
  endfunction

  // Core domain is up in every state but reset and shutdown
  function automatic logic core_on(input pss_pkg::pwr_state_t s);
    core_on = (s != pss_pkg::ST_SHUTDN) && (s != pss_pkg::ST_RESET);
  endfunction

  // Crystal runs wherever the core does, except in full sleep
  function automatic logic xo_on(input pss_pkg::pwr_state_t s);
    xo_on = core_on(s) && (s != pss_pkg::ST_SLEEP);
  endfunction

  // Host interface is powered only while listening
  function automatic logic hif_on(input pss_pkg::pwr_state_t s);
    hif_on = (s == pss_pkg::ST_LISTEN);
  endfunction

  // Next state; the low power tick paces beacons when it is present,
  // otherwise the reference clock counts so wake-ups still happen
  always_comb begin
    d = q;
    d.wake_sync = {q.wake_sync[1:0], wake_request_pin};
    // Wake level moves only once stages two and three agree, so a
    // sample caught mid-transition cannot flicker the state machine
    if (q.wake_sync[1] == q.wake_sync[2]) begin
      d.wake_lvl = q.wake_sync[2];
    end
    case (q.st)
      // Reset pin has just risen: begin the full start-up sequence
      pss_pkg::ST_RESET: begin
        d.st  = pss_pkg::ST_STARTUP;
        d.cnt = `PSS_CNT_ZERO;
      end

      // Start-up runs its whole length before the host can talk
      pss_pkg::ST_STARTUP: begin
        if (startup_done) begin
          d.st  = pss_pkg::ST_LISTEN;
          d.cnt = `PSS_CNT_ZERO;
        end else begin
          d.cnt = cnt_inc;
        end
      end

      // Listen: shutdown first, then the beacon window, then a rest
      pss_pkg::ST_LISTEN: begin
        if (shutdown_req && !wake_hi) begin
          d.st = pss_pkg::ST_SHUTDN;
        end else if (!power_save_en) begin
          d.rx  = 1'h0;
          d.cnt = `PSS_CNT_ZERO;
        end else if (window_open) begin
          d.cnt = cnt_inc;             // Beacon window still open
        end else if (may_rest) begin
          d.st  = pick_rest(lp_present, keep_crystal_on, prefer_snooze);
          d.rx  = 1'h0;
          d.cnt = `PSS_CNT_ZERO;
        end else begin
          d.rx = 1'h0;
        end
      end

      // Rest states: a host wake wins over the beacon timer
      pss_pkg::ST_SLEEP, pss_pkg::ST_SLP_XO, pss_pkg::ST_SNOOZE: begin
        if (wake_hi) begin
          d.st  = pss_pkg::ST_LISTEN;  // Host wake
          d.cnt = `PSS_CNT_ZERO;
        end else if (q.st == pss_pkg::ST_SLEEP && !lp_present) begin
          d.st = pss_pkg::ST_SLP_XO;   // Lost the slow clock
        end else if (beacon_due) begin
          d.st  = pss_pkg::ST_LISTEN;  // Beacon due
          d.rx  = 1'h1;
          d.cnt = `PSS_CNT_ZERO;
        end else if (rest_count) begin
          d.cnt = cnt_inc;
        end
      end

      // Shutdown is left only through the reset pin
      pss_pkg::ST_SHUTDN: begin
        d.st = pss_pkg::ST_SHUTDN;
      end

      // A corrupted state code restarts from reset
      default: begin
        d.st = pss_pkg::ST_RESET;
      end
    endcase
    // Power rails follow the next state
    d.core = core_on(d.st);
    d.xo   = xo_on(d.st);
    d.hif  = hif_on(d.st);
    d.boot = (d.st == pss_pkg::ST_STARTUP);
  end

  // Synchronous reset holds everything still while the pin is low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q    <= '0;
      q.st <= pss_pkg::ST_RESET;
    end else begin
      q <= d;
    end
  end

  // Rail enables come straight from their flops, no logic after them
  assign crystal_oscillator_en = q.xo;
  assign host_if_en            = q.hif;
  assign core_power_en         = q.core;

  // Status outputs, also direct register fields
  assign beacon_rx             = q.rx;
  assign startup_busy          = q.boot;
  assign power_state           = q.st;
endmodule
`default_nettype wire

// *** tb/pss_chk.sv ***
// Port assertions for the power state sequencer
`timescale 1ns/1ns
`default_nettype none
module pss_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Firmware controls
  input wire logic       power_save_en,
  input wire logic       associated,
  input wire logic       traffic_busy,
  input wire logic       tasks_pending,
  input wire logic       shutdown_req,
  // Power controls and status
  input wire logic       crystal_oscillator_en,
  input wire logic       host_if_en,
  input wire logic       core_power_en,
  input wire logic       startup_busy,
  input wire logic [6:0] power_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_reset_release: assert property (
    rst_b && !$past(rst_b) |-> power_state == 7'h01 && !core_power_en
    ##1 power_state == 7'h02 && startup_busy) else $error("reset exit");
  a_sleep_dark: assert property (power_state == 7'h08 |->
    !crystal_oscillator_en && !host_if_en) else $error("sleep with xo");
  a_xo_kept: assert property (power_state inside {7'h10, 7'h20} |->
    crystal_oscillator_en) else $error("xo off in rest");
  a_hif_listen: assert property (host_if_en |->
    power_state == 7'h04) else $error("host if on off listen");
  a_listen_stays: assert property (power_state == 7'h04 &&
    !power_save_en && !shutdown_req |=> power_state == 7'h04)
    else $error("left listen");
  a_busy_held: assert property (power_state == 7'h04 && traffic_busy &&
    !shutdown_req |=> power_state == 7'h04) else $error("rest in traffic");
  a_unassoc_idle: assert property (power_state == 7'h04 && !associated &&
    tasks_pending && !shutdown_req |=> power_state == 7'h04)
    else $error("rest with tasks");
  a_shutdown_held: assert property (power_state == 7'h40 |=>
    $stable(power_state) && !core_power_en) else $error("left shutdown");
endmodule
bind power_state_sequencer pss_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .power_save_en(power_save_en), .associated(associated),
  .traffic_busy(traffic_busy), .tasks_pending(tasks_pending),
  .shutdown_req(shutdown_req), .crystal_oscillator_en(crystal_oscillator_en),
  .host_if_en(host_if_en), .core_power_en(core_power_en),
  .startup_busy(startup_busy), .power_state(power_state));
`default_nettype wire

// *** tb/host_model.sv ***
// Host pins and low power clock source model
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Bench commands
  input  wire logic ref_clk,
  input  wire logic rst_cmd,
  input  wire logic wake_cmd,
  input  wire logic lp_cmd,
  // Device pins
  output logic      rst_b,
  output logic      wake_request_pin,
  output logic      low_power_clock_in
);
  logic [3:0] div_q = 4'h0;
  initial {rst_b, wake_request_pin, low_power_clock_in} = 3'h0;
  // Pins move just after the edge; the slow clock stands low when off
  always @(posedge ref_clk) begin
    div_q <= div_q + 4'h1;
    rst_b <= !rst_cmd;
    wake_request_pin <= wake_cmd;
    low_power_clock_in <= lp_cmd & div_q[3];
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the power state sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       ref_clk = 1'h0, rst_cmd = 1'h1, wake_cmd = 1'h0, lp_cmd = 1'h1;
  logic       pse = 1'h0, kxo = 1'h0, psn = 1'h0, asc = 1'h1;
  logic       tbz = 1'h0, tpd = 1'h0, sdr = 1'h0;
  logic       rst_b, wake, lpc, xo, hif, core, brx, sbz;
  logic [6:0] st;
  int         num_errors = 0;
  int         tests_run = 0;
  // 50 MHz reference
  initial forever #10 ref_clk = ~ref_clk;
  host_model i_host (.ref_clk(ref_clk), .rst_cmd(rst_cmd),
    .wake_cmd(wake_cmd), .lp_cmd(lp_cmd), .rst_b(rst_b),
    .wake_request_pin(wake), .low_power_clock_in(lpc));
  // Short counts keep the run brief
  power_state_sequencer #(.BEACON_TICKS(16'h0004), .BEACON_RX(16'h0004),
    .STARTUP(16'h0004), .LP_TIMEOUT(16'h0040)) i_dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .wake_request_pin(wake), .low_power_clock_in(lpc),
    .power_save_en(pse), .keep_crystal_on(kxo), .prefer_snooze(psn),
    .associated(asc), .traffic_busy(tbz), .tasks_pending(tpd),
    .shutdown_req(sdr), .crystal_oscillator_en(xo), .host_if_en(hif),
    .core_power_en(core), .beacon_rx(brx), .startup_busy(sbz),
    .power_state(st));
  task automatic chk(string n, logic [6:0] e, logic [6:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk_flag(string n, logic e, logic s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bounded poll, so a stuck state shows as a mismatch, not a hang
  task automatic wst(logic [6:0] e, int n);
    repeat (n) if (st !== e) @(negedge ref_clk);
    chk("power_state", e, st);
  endtask
  task automatic wake_out;
    wake_cmd = 1'h1;
    wst(7'h04, 10);
    {pse, kxo, psn, asc, wake_cmd} = 5'h02;
    cyc(8);
  endtask
  task automatic boot;
    rst_cmd = 1'h1;
    cyc(10);
    chk("reset", 7'h01, st);
    rst_cmd = 1'h0;
    wst(7'h02, 4);
    chk_flag("startup_busy", 1'h1, sbz);
    chk_flag("core_power", 1'h1, core);
    wst(7'h04, 12);
    tbz = 1'h1;
    cyc(30);
    tbz = 1'h0;
    chk("listen", 7'h04, st);
    $display("end boot");
  endtask
  task automatic t_sleep;
    {tbz, pse} = 2'h3;
    cyc(6);
    chk("traffic", 7'h04, st);
    tbz = 1'h0;
    wst(7'h08, 4);
    chk_flag("crystal", 1'h0, xo);
    chk_flag("host_if", 1'h0, hif);
    wst(7'h04, 120);
    chk("beacon_rx", 7'h01, {6'h00, brx});
    chk_flag("host_if", 1'h1, hif);
    wst(7'h08, 20);
    wake_out;
    $display("end sleep");
  endtask
  task automatic t_xo;
    {kxo, pse} = 2'h3;
    wst(7'h10, 8);
    chk_flag("crystal", 1'h1, xo);
    wake_out;
    {lp_cmd, psn} = 2'h1;
    cyc(80);
    pse = 1'h1;
    wst(7'h20, 12);
    chk_flag("crystal", 1'h1, xo);
    wake_out;
    pse = 1'h1;
    wst(7'h10, 12);
    chk_flag("crystal", 1'h1, xo);
    wake_out;
    lp_cmd = 1'h1;
    cyc(40);
    $display("end xo");
  endtask
  task automatic t_unassoc;
    {asc, tpd, pse} = 3'h3;
    cyc(20);
    chk("tasks", 7'h04, st);
    tpd = 1'h0;
    wst(7'h08, 6);
    wake_out;
    $display("end unassoc");
  endtask
  task automatic t_shut;
    sdr = 1'h1;
    wst(7'h40, 6);
    chk_flag("core_power", 1'h0, core);
    sdr = 1'h0;
    cyc(20);
    chk("shutdown", 7'h40, st);
    boot;
  endtask
  task automatic give_verdict;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    boot;
    t_sleep;
    t_xo;
    t_unassoc;
    t_shut;
    give_verdict;
  end
  // Watchdog, well past the longest possible run of about 560 cycles
  initial begin
    cyc(3000);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
